/* rtl/obl_top.sv */
// Module: five output bit stages with an AHB-Lite register port.
// Assumes all inputs are synchronous to ref_clk_i; zero wait-state slave.

//Contract
// - Digits three and four invert C, D
// - Digit 0 passes, 1 inverts source
// - Input polarity resets to 0000
// - Five outputs, each with own settings
// - Result polarity 0 direct, 1 inverted
// - Latch 0 follows result every cycle
// - Latch 1 holds ON until release
// - Latch 2 holds OFF, not power-on
// - Release by reset, command, mode 0
// - Settings writable only for functions 1-4
// - Operation type encodings and functions 1-4
// - Default type shows heat, cool, events
// - Codes 48, 49 feed back outputs
module obl_top (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    // Control sources
    input wire logic heat_control_output_i,
    input wire logic cool_control_output_i,
    input wire logic [2:0] internal_event_i,
    input wire logic [63:0] src_vec_i,
    input wire logic release_key_i,
    input wire logic [1:0] ctrl_relay_type_i,
    // Physical outputs
    output logic [1:0] ctrl_out_o,
    output logic [2:0] evt_out_o
);

    localparam int N = obl_pkg::OBL_NUM_OUT;
    localparam int SW = obl_pkg::OBL_SRC_W;

    // Per-output settings
    logic [3:0] inp_pol_reg [N];
    logic [3:0] inp_pol_next [N];
    logic res_pol_reg [N];
    logic res_pol_next [N];
    logic [1:0] latch_reg [N];
    logic [1:0] latch_next [N];
    logic [2:0] op_reg [N];
    logic [2:0] op_next [N];
    logic [SW-1:0] asn_reg [N][4];
    logic [SW-1:0] asn_next [N][4];

    // Bus state
    logic wr_pend_reg;
    logic wr_pend_next;
    logic [7:0] addr_reg;
    logic [7:0] addr_next;
    logic [31:0] hrdata_reg;
    logic [31:0] hrdata_next;
    logic hready_reg;
    logic release_reg;
    logic release_next;

    // Stage links
    logic [N-1:0] out_state;
    logic [N-1:0] held;
    logic [N-1:0] access_ok;
    logic [N-1:0] direct_bit;
    logic [3:0] sel_src [N];
    logic [63:0] src_fb;
    logic addr_ok;

    obl_stage_if sif [N] ();

    assign addr_ok = hsel_i && htrans_i[1] && hready_i;

    // Feedback codes replace two entries of the source vector
    always_comb begin
        src_fb = src_vec_i;
        src_fb[obl_pkg::OBL_SRC_EVT1_FB] = out_state[2];
        src_fb[obl_pkg::OBL_SRC_CTRL1_FB] = out_state[0];
    end

    // Source selection and default outputs
    always_comb begin
        for (int i = 0; i < N; i++) begin
            for (int k = 0; k < 4; k++) begin
                sel_src[i][k] = src_fb[asn_reg[i][k]];
            end
            // Event outputs are always present; control outputs need relay or pulse
            if (i < obl_pkg::OBL_NUM_CTRL) begin
                access_ok[i] = ctrl_relay_type_i[i] && (op_reg[i] >= obl_pkg::OBL_OP_FUNC1)
                    && (op_reg[i] <= obl_pkg::OBL_OP_FUNC4);
            end else begin
                access_ok[i] = (op_reg[i] >= obl_pkg::OBL_OP_FUNC1)
                    && (op_reg[i] <= obl_pkg::OBL_OP_FUNC4);
            end
            if (op_reg[i] == obl_pkg::OBL_OP_HEAT) begin
                direct_bit[i] = heat_control_output_i;
            end else if (op_reg[i] == obl_pkg::OBL_OP_COOL) begin
                direct_bit[i] = cool_control_output_i;
            end else if (i == 0) begin
                direct_bit[i] = heat_control_output_i;
            end else if (i == 1) begin
                direct_bit[i] = cool_control_output_i;
            end else begin
                direct_bit[i] = internal_event_i[i-2];
            end
        end
    end

    // Five stages, each with its own settings
    for (genvar g = 0; g < N; g++) begin : g_stage
        assign sif[g].inp_pol = inp_pol_reg[g];
        assign sif[g].res_pol = res_pol_reg[g];
        assign sif[g].latch_mode = latch_reg[g];
        assign sif[g].op_type = op_reg[g];
        assign sif[g].src = sel_src[g];
        assign sif[g].direct_bit = direct_bit[g];
        assign sif[g].release_all = release_reg;
        assign out_state[g] = sif[g].out_state;
        assign held[g] = sif[g].held;

        obl_bit_stage u_stage (
            .ref_clk_i(ref_clk_i),
            .rst_b_i(rst_b_i),
            .sif(sif[g])
        );
    end

    // Read data for an address
    function automatic logic [31:0] rd_word(input logic [7:0] a);
        logic [31:0] w;
        w = 32'h0;
        if (a >= obl_pkg::OBL_CFG_BASE && a < obl_pkg::OBL_CFG_BASE + 8'h14
            && a[1:0] == 2'h0) begin
            for (int i = 0; i < N; i++) begin
                if (a == obl_pkg::OBL_CFG_BASE + 8'(4 * i)) begin
                    w[obl_pkg::OBL_INP_POL_LSB +: 4] = inp_pol_reg[i];
                    w[obl_pkg::OBL_RES_POL_BIT] = res_pol_reg[i];
                    w[obl_pkg::OBL_LATCH_LSB +: 2] = latch_reg[i];
                    w[obl_pkg::OBL_OP_LSB +: 3] = op_reg[i];
                end
            end
        end else if (a >= obl_pkg::OBL_ASN_BASE && a < obl_pkg::OBL_ASN_BASE + 8'h14
            && a[1:0] == 2'h0) begin
            for (int i = 0; i < N; i++) begin
                if (a == obl_pkg::OBL_ASN_BASE + 8'(4 * i)) begin
                    for (int k = 0; k < 4; k++) begin
                        w[k * obl_pkg::OBL_ASN_STRIDE +: SW] = asn_reg[i][k];
                    end
                end
            end
        end else if (a == obl_pkg::OBL_STAT_OFS) begin
            w[N-1:0] = out_state;
            w[obl_pkg::OBL_STAT_HELD_LSB +: N] = held;
        end else begin
            w = 32'h0;
        end
        return w;
    endfunction : rd_word

    // Bus phases and register writes
    always_comb begin
        // Writes outside the 256-byte window must not alias onto the registers
        wr_pend_next = addr_ok && hwrite_i && (haddr_i[31:8] == 24'h0);
        addr_next = addr_ok ? haddr_i[7:0] : addr_reg;
        hrdata_next = hrdata_reg;
        if (addr_ok && !hwrite_i) begin
            hrdata_next = (haddr_i[31:8] == 24'h0) ? rd_word(haddr_i[7:0]) : 32'h0;
        end
        release_next = release_key_i;
        for (int i = 0; i < N; i++) begin
            inp_pol_next[i] = inp_pol_reg[i];
            res_pol_next[i] = res_pol_reg[i];
            latch_next[i] = latch_reg[i];
            op_next[i] = op_reg[i];
            for (int k = 0; k < 4; k++) begin
                asn_next[i][k] = asn_reg[i][k];
            end
        end
        if (wr_pend_reg) begin
            for (int i = 0; i < N; i++) begin
                if (addr_reg == obl_pkg::OBL_CFG_BASE + 8'(4 * i)) begin
                    op_next[i] = hwdata_i[obl_pkg::OBL_OP_LSB +: 3];
                    // Hidden settings keep their value while the type is not a function
                    if (access_ok[i]) begin
                        inp_pol_next[i] = hwdata_i[obl_pkg::OBL_INP_POL_LSB +: 4];
                        res_pol_next[i] = hwdata_i[obl_pkg::OBL_RES_POL_BIT];
                        latch_next[i] = hwdata_i[obl_pkg::OBL_LATCH_LSB +: 2];
                    end
                end else if (addr_reg == obl_pkg::OBL_ASN_BASE + 8'(4 * i)) begin
                    if (access_ok[i]) begin
                        for (int k = 0; k < 4; k++) begin
                            asn_next[i][k] = hwdata_i[k * obl_pkg::OBL_ASN_STRIDE +: SW];
                        end
                    end
                end
            end
            if (addr_reg == obl_pkg::OBL_CMD_OFS && hwdata_i[obl_pkg::OBL_CMD_RELEASE_BIT]) begin
                release_next = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_pend_reg <= 1'b0;
            addr_reg <= 8'h00;
            hrdata_reg <= 32'h0;
            hready_reg <= 1'b0;
            release_reg <= 1'b0;
            for (int i = 0; i < N; i++) begin
                inp_pol_reg[i] <= obl_pkg::OBL_INP_POL_RST;
                res_pol_reg[i] <= obl_pkg::OBL_RES_POL_RST;
                latch_reg[i] <= obl_pkg::OBL_LATCH_RST;
                op_reg[i] <= obl_pkg::OBL_OP_RST;
                asn_reg[i][0] <= obl_pkg::OBL_ASN_A_RST[i * SW +: SW];
                for (int k = 1; k < 4; k++) begin
                    asn_reg[i][k] <= obl_pkg::OBL_ASN_OTHER_RST;
                end
            end
        end else begin
            wr_pend_reg <= wr_pend_next;
            addr_reg <= addr_next;
            hrdata_reg <= hrdata_next;
            hready_reg <= 1'b1;
            release_reg <= release_next;
            for (int i = 0; i < N; i++) begin
                inp_pol_reg[i] <= inp_pol_next[i];
                res_pol_reg[i] <= res_pol_next[i];
                latch_reg[i] <= latch_next[i];
                op_reg[i] <= op_next[i];
                for (int k = 0; k < 4; k++) begin
                    asn_reg[i][k] <= asn_next[i][k];
                end
            end
        end
    end

    // Outputs other than hresp_o come from the stage flops and the bus flops
    assign hreadyout_o = hready_reg;
    assign hresp_o = 1'b0;
    assign hrdata_o = hrdata_reg;
    assign ctrl_out_o = out_state[1:0];
    assign evt_out_o = out_state[4:2];

endmodule : obl_top

/* rtl/obl_pkg.sv */
// Package: constants of the output bit polarity and latch stage.
// Assumes a 32-bit AHB-Lite register port and five output stages.
package obl_pkg;

    // Stage count: control outputs 1-2 then event outputs 1-3
    localparam int OBL_NUM_OUT = 5;
    localparam int OBL_NUM_CTRL = 2;

    // Register byte offsets
    localparam logic [7:0] OBL_CFG_BASE = 8'h00;
    localparam logic [7:0] OBL_ASN_BASE = 8'h20;
    localparam logic [7:0] OBL_CMD_OFS = 8'h40;
    localparam logic [7:0] OBL_STAT_OFS = 8'h44;

    // Config register fields
    localparam int OBL_INP_POL_LSB = 0;
    localparam int OBL_RES_POL_BIT = 4;
    localparam int OBL_LATCH_LSB = 5;
    localparam int OBL_OP_LSB = 8;

    // Assignment register: four 6-bit source codes, one per byte
    localparam int OBL_ASN_STRIDE = 8;
    localparam int OBL_SRC_W = 6;

    // Status register fields
    localparam int OBL_STAT_HELD_LSB = 8;

    // Command register field
    localparam int OBL_CMD_RELEASE_BIT = 0;

    // Values after reset
    localparam logic [3:0] OBL_INP_POL_RST = 4'h0;
    localparam logic OBL_RES_POL_RST = 1'b0;
    localparam logic [1:0] OBL_LATCH_RST = 2'h0;
    localparam logic [2:0] OBL_OP_RST = 3'h0;
    // Source A reset codes for outputs 0..4, six bits each
    localparam logic [29:0] OBL_ASN_A_RST = {6'h04, 6'h03, 6'h02, 6'h0F, 6'h0E};
    localparam logic [5:0] OBL_ASN_OTHER_RST = 6'h00;

    // Operation types
    localparam logic [2:0] OBL_OP_DEFAULT = 3'h0;
    localparam logic [2:0] OBL_OP_HEAT = 3'h1;
    localparam logic [2:0] OBL_OP_COOL = 3'h2;
    localparam logic [2:0] OBL_OP_FUNC1 = 3'h3;
    localparam logic [2:0] OBL_OP_FUNC2 = 3'h4;
    localparam logic [2:0] OBL_OP_FUNC3 = 3'h5;
    localparam logic [2:0] OBL_OP_FUNC4 = 3'h6;

    // Latch modes
    localparam logic [1:0] OBL_LATCH_NONE = 2'h0;
    localparam logic [1:0] OBL_LATCH_ON = 2'h1;
    localparam logic [1:0] OBL_LATCH_OFF = 2'h2;

    // Feedback source codes
    localparam logic [5:0] OBL_SRC_EVT1_FB = 6'h30;
    localparam logic [5:0] OBL_SRC_CTRL1_FB = 6'h31;

endpackage : obl_pkg

/* rtl/obl_stage_if.sv */
// Interface: settings and result of one output stage.
// Assumes the top drives settings and the stage drives its state.
interface obl_stage_if;
    logic [3:0] inp_pol;
    logic res_pol;
    logic [1:0] latch_mode;
    logic [2:0] op_type;
    logic [3:0] src;
    logic direct_bit;
    logic release_all;
    logic out_state;
    logic held;

    modport cfg (
        output inp_pol, res_pol, latch_mode, op_type, src, direct_bit, release_all,
        input out_state, held
    );
    modport stage (
        input inp_pol, res_pol, latch_mode, op_type, src, direct_bit, release_all,
        output out_state, held
    );
endinterface : obl_stage_if

/* rtl/obl_bit_stage.sv */
// Module: one output stage, polarity, function, result polarity, latch.
// Assumes source bits are already selected and synchronous to the clock.
module obl_bit_stage (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // Settings and state
    obl_stage_if.stage sif
);

    logic out_reg;
    logic out_next;
    logic held_reg;
    logic held_next;
    logic [3:0] pol_src;
    logic func_bit;
    logic is_func;
    logic result;
    logic latch_on;
    logic latch_off;
    logic set_held;

    always_comb begin
        pol_src = sif.src ^ sif.inp_pol;
        is_func = 1'b1;
        case (sif.op_type)
            obl_pkg::OBL_OP_FUNC1: func_bit = (pol_src[0] & pol_src[1]) | (pol_src[2] & pol_src[3]);
            obl_pkg::OBL_OP_FUNC2: func_bit = (pol_src[0] | pol_src[1]) & (pol_src[2] | pol_src[3]);
            obl_pkg::OBL_OP_FUNC3: func_bit = |pol_src;
            obl_pkg::OBL_OP_FUNC4: func_bit = &pol_src;
            default: begin
                func_bit = 1'b0;
                is_func = 1'b0;
            end
        endcase
        // Non-function types bypass polarity and latch entirely
        result = is_func ? (func_bit ^ sif.res_pol) : sif.direct_bit;
        latch_on = is_func && (sif.latch_mode == obl_pkg::OBL_LATCH_ON);
        latch_off = is_func && (sif.latch_mode == obl_pkg::OBL_LATCH_OFF);
        // OFF latch engages only on a real ON to OFF edge, never the reset OFF
        set_held = (latch_on && result) || (latch_off && out_reg && !result);
        // Mode 0 drops the hold; a new engage wins over a release
        held_next = set_held || (held_reg && (latch_on || latch_off) && !sif.release_all);
        if (held_next) begin
            out_next = latch_on;
        end else begin
            out_next = result;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            out_reg <= 1'b0;
            held_reg <= 1'b0;
        end else begin
            out_reg <= out_next;
            held_reg <= held_next;
        end
    end

    assign sif.out_state = out_reg;
    assign sif.held = held_reg;

endmodule : obl_bit_stage

/* tb/obl_relay_model.sv */
// Model: relay or voltage pulse drivers on the five stage outputs.
// Assumes the stage outputs are flops on ref_clk_i.
module obl_relay_model (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // Drive and contact
    input wire logic [4:0] drive_i,
    output logic [4:0] contact_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Contacts open while unpowered; one cycle of pick-up delay
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            contact_o <= 5'h00;
        end else begin
            contact_o <= drive_i;
        end
    end
endmodule : obl_relay_model

/* tb/obl_top_chk.sv */
// Checker: bus and fixed-output properties of obl_top.
// Assumes it is bound to obl_top and sees only its ports.
module obl_top_chk (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // Bus
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic [31:0] hrdata_o,
    // Sources and outputs
    input wire logic heat_control_output_i,
    input wire logic cool_control_output_i,
    input wire logic [2:0] internal_event_i,
    input wire logic release_key_i,
    input wire logic [1:0] ctrl_out_o,
    input wire logic [2:0] evt_out_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    logic req;
    logic wr_reg, wr_next;
    logic [7:0] wa_reg, wa_next;
    logic [2:0] op_reg [5];
    logic [2:0] op_next [5];
    logic [4:0] fix_reg, fix_next;
    logic [4:0] dflt;
    assign req = hsel_i && htrans_i[1] && hready_i && haddr_i[31:8] == 24'h000000;
    // Op types mirrored from bus writes; the op field is never gated
    always_comb begin
        wr_next = req && hwrite_i;
        wa_next = haddr_i[7:0];
        op_next = op_reg;
        dflt = {internal_event_i, cool_control_output_i, heat_control_output_i};
        if (wr_reg && wa_reg < 8'h14 && wa_reg[1:0] == 2'h0) begin
            op_next[wa_reg[4:2]] = hwdata_i[10:8];
        end
        for (int n = 0; n < 5; n++) begin
            fix_next[n] = (op_reg[n] == 3'h1) ? heat_control_output_i :
                (op_reg[n] == 3'h2) ? cool_control_output_i :
                dflt[n];
        end
    end
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_reg <= 1'b0;
            wa_reg <= 8'h00;
            op_reg <= '{default: 3'h0};
            fix_reg <= 5'h00;
        end else begin
            wr_reg <= wr_next;
            wa_reg <= wa_next;
            op_reg <= op_next;
            fix_reg <= fix_next;
        end
    end
    okay_resp_a: assert property (hresp_o == 1'b0) else $error("response not OKAY");
    ready_up_a: assert property ($past(rst_b_i) |-> hreadyout_o) else $error("wait state");
    unmapped_zero_a: assert property (req && !hwrite_i && haddr_i[7:0] >= 8'h40 &&
        haddr_i[7:0] != 8'h44 |=> hrdata_o == 32'h0) else $error("nonzero read data");
    rdata_hold_a: assert property (!(req && !hwrite_i) |=> $stable(hrdata_o))
        else $error("read data moved");
    status_mirror_a: assert property (req && !hwrite_i && haddr_i[7:0] == 8'h44 |=>
        hrdata_o[7:0] == {3'h0, $past(evt_out_o), $past(ctrl_out_o)}) else $error("status");
    ctrl1_fixed_a: assert property (op_reg[0] < 3'h3 |=> ctrl_out_o[0] == fix_reg[0])
        else $error("control output 1 fixed mode");
    ctrl2_fixed_a: assert property (op_reg[1] < 3'h3 |=> ctrl_out_o[1] == fix_reg[1])
        else $error("control output 2 fixed mode");
    evt1_fixed_a: assert property (op_reg[2] < 3'h3 |=> evt_out_o[0] == fix_reg[2])
        else $error("event output 1 fixed mode");
    evt3_fixed_a: assert property (op_reg[4] < 3'h3 |=> evt_out_o[2] == fix_reg[4])
        else $error("event output 3 fixed mode");
    func_write_c: cover property (wr_reg && wa_reg < 8'h14 && hwdata_i[10:8] > 3'h2);
    status_read_c: cover property (req && !hwrite_i && haddr_i[7:0] == 8'h44);
    key_release_c: cover property (release_key_i);
endmodule : obl_top_chk
bind obl_top obl_top_chk i_obl_top_chk (.*);

/* tb/output_bit_polarity_latch_test.sv */
// Testbench: five output stages set up over AHB-Lite, relay model on the outputs.
// Assumes a zero wait-state slave and the register map of obl_pkg.
module output_bit_polarity_latch_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i, rst_b_i, hwrite, heat, cool, key, hready, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, relay_type, ctrl_out;
    logic [2:0] evt, evt_out;
    logic [63:0] src_vec;
    logic [4:0] contact;
    logic [15:0] seed;
    int mismatches, num_checks;
    wire [4:0] outs = {evt_out, ctrl_out};
    obl_top i_obl_top (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .hsel_i(1'b1),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp),
        .hrdata_o(hrdata), .heat_control_output_i(heat), .cool_control_output_i(cool),
        .internal_event_i(evt), .src_vec_i(src_vec), .release_key_i(key),
        .ctrl_relay_type_i(relay_type), .ctrl_out_o(ctrl_out), .evt_out_o(evt_out));
    obl_relay_model i_obl_relay_model (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
        .drive_i(outs), .contact_o(contact));
    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic exp_fn(input logic [2:0] op, input logic [3:0] pol,
        input logic rp, input logic [3:0] s);
        logic [3:0] v;
        v = s ^ pol;
        case (op)
            3'h3: return ((v[0] & v[1]) | (v[2] & v[3])) ^ rp;
            3'h4: return ((v[0] | v[1]) & (v[2] | v[3])) ^ rp;
            3'h5: return (|v) ^ rp;
            default: return (&v) ^ rp;
        endcase
    endfunction : exp_fn
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wrap_up();
        $display("mismatches %0d checks %0d", mismatches, num_checks);
        if (mismatches == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge ref_clk_i); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk_i); while (hready !== 1'b1);
        rd = hrdata;
    endtask : xfer
    task automatic settle(input int c);
        repeat (c) @(posedge ref_clk_i);
        #1;
    endtask : settle
    // Op type first: the other fields are only taken once a function is stored
    task automatic setup(input int n, input logic [2:0] op, input logic [7:0] low,
        input logic [31:0] asn);
        xfer(8'(4 * n), 1'b1, {21'h0, op, 8'h00});
        xfer(8'(4 * n), 1'b1, {21'h0, op, low});
        xfer(8'(8'h20 + 4 * n), 1'b1, asn);
    endtask : setup
    task automatic put(input logic b);
        @(posedge ref_clk_i);
        src_vec <= {64{b}};
        settle(2);
    endtask : put
    task automatic key_pulse();
        @(posedge ref_clk_i);
        key <= 1'b1;
        @(posedge ref_clk_i);
        key <= 1'b0;
        settle(4);
    endtask : key_pulse
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        mismatches++;
        wrap_up();
    end
    initial begin
        int n;
        logic [2:0] op;
        logic [7:0] low;
        logic [31:0] asn;
        {haddr, hwdata, htrans, hwrite, heat, cool, evt, src_vec, key} = '0;
        relay_type = 2'h3;
        seed = 16'h0016;
        rst_b_i = 1'b0;
        repeat (12) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        settle(2);
        for (int i = 0; i < 5; i++) begin
            xfer(8'(4 * i), 1'b0, 32'h0);
            check("cfg reset", rd, 32'h0);
            xfer(8'(8'h20 + 4 * i), 1'b0, 32'h0);
            check("asn reset", rd, {26'h0, obl_pkg::OBL_ASN_A_RST[6 * i +: 6]});
        end
        xfer(8'h80, 1'b1, 32'hFFFF_FFFF);
        xfer(8'h80, 1'b0, 32'h0);
        check("unmapped", rd, 32'h0);
        for (int o = 0; o < 3; o++) begin
            for (int i = 0; i < 5; i++) begin
                xfer(8'(4 * i), 1'b1, 32'(o) << 8);
            end
            repeat (6) begin
                seed = lfsr(seed);
                @(posedge ref_clk_i);
                {heat, cool, evt} <= seed[4:0];
                settle(2);
                check("fixed", outs, o == 0 ? {evt, cool, heat} : {5{o == 1 ? heat : cool}});
            end
        end
        xfer(8'h00, 1'b1, 32'h0000_007F);
        xfer(8'h00, 1'b0, 32'h0);
        check("locked cfg", rd, 32'h0);
        relay_type <= 2'h2;
        setup(0, 3'h3, 8'h1F, 32'h0505_0505);
        xfer(8'h00, 1'b0, 32'h0);
        check("no relay cfg", rd, 32'h0000_0300);
        xfer(8'h20, 1'b0, 32'h0);
        check("no relay asn", rd, 32'h0000_000E);
        relay_type <= 2'h3;
        repeat (40) begin
            seed = lfsr(seed);
            n = seed % 5;
            op = 3'h3 + 3'(seed[5:4]);
            low = {3'h0, seed[10:6]};
            seed = lfsr(seed);
            asn = {2{seed}} & 32'h1F1F_1F1F;
            setup(n, op, low, asn);
            xfer(8'(4 * n), 1'b0, 32'h0);
            check("cfg back", rd, {21'h0, op, low});
            // Codes repeat every 16 bits of the source vector
            for (int k = 0; k < 2; k++) begin
                seed = lfsr(seed);
                @(posedge ref_clk_i);
                src_vec <= {4{seed}};
                settle(2);
                check("func out", outs[n], exp_fn(op, low[3:0], low[4], {seed[asn[27:24]],
                    seed[asn[19:16]], seed[asn[11:8]], seed[asn[3:0]]}));
            end
        end
        put(1'b0);
        setup(3, 3'h5, 8'h20, 32'h0505_0505);
        put(1'b1);
        put(1'b0);
        check("on latch", outs[3], 1'b1);
        xfer(8'h44, 1'b0, 32'h0);
        check("held flags", rd[12:8], 5'h08);
        xfer(8'h40, 1'b1, 32'h1);
        settle(4);
        check("cmd release", outs[3], 1'b0);
        put(1'b1);
        put(1'b0);
        key_pulse();
        check("key release", outs[3], 1'b0);
        put(1'b1);
        put(1'b0);
        xfer(8'h0C, 1'b1, 32'h0000_0500);
        settle(2);
        check("mode0 release", outs[3], 1'b0);
        setup(4, 3'h5, 8'h40, 32'h0505_0505);
        put(1'b1);
        check("off latch idle", outs[4], 1'b1);
        put(1'b0);
        put(1'b1);
        check("off latch", outs[4], 1'b0);
        key_pulse();
        check("off release", outs[4], 1'b1);
        // Feedback codes: control 2 follows control 1, event 2 follows event 1
        put(1'b0);
        xfer(8'h00, 1'b1, 32'h0000_0100);
        xfer(8'h08, 1'b1, 32'h0000_0000);
        setup(1, 3'h5, 8'h00, 32'h0000_0031);
        setup(3, 3'h5, 8'h00, 32'h0000_0030);
        for (int b = 1; b >= 0; b--) begin
            @(posedge ref_clk_i);
            {heat, evt} <= {b[0], 3'(b)};
            settle(3);
            check("fb ctrl1", outs[1], b[0]);
            check("fb evt1", outs[3], b[0]);
        end
        check("relay", contact, outs);
        wrap_up();
    end
endmodule : output_bit_polarity_latch_test
